//--- rtl/pcl_top.sv
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "pcl_params.svh"

// Contract
// - Edge input A sets A flag 7 on edge picked by bit 1; bit 0 gates IRQ.
// - Flag 7 sets on each active edge regardless of enable; sides identical.
// - Bit 0 only gates the interrupt output, never flag setting.
// - Bit 5 low: line 2 is input, sets flag 6 on bit-4 edge; bit 3 gates.
// - Flag 6 sets on each active line-2 edge in input mode, both sides.
// - Bit 3 in input mode only enables interrupt from flag 6.
// - A read handshake: line A2 goes high on active edge of edge input A.
// - A read handshake: line A2 goes low on processor read of port A data.
// - A pulse mode: line A2 low one cycle after each port A data read.
// - B write handshake: line B2 goes low on processor write of port B data.
// - B write handshake: line B2 returns high on active edge of input B.
// - B pulse mode: line B2 low one cycle after each port B data write.
// - A manual output: line A2 follows control bit 3.
// - Reading a side's port data clears that side's flags 6 and 7.
module pcl_top
    import pcl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire logic [`PCL_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Peripheral data input A and output B
    input wire logic [7:0] port_a_in,
    output logic [7:0] port_b_out,
    // Side A lines
    input wire logic edge_input_a,
    input wire logic control_line_a2_in,
    output logic control_line_a2_out,
    output logic control_line_a2_oe,
    // Side B lines
    input wire logic edge_input_b,
    input wire logic control_line_b2_in,
    output logic control_line_b2_out,
    output logic control_line_b2_oe,
    // Interrupts
    output logic interrupt_out_a_b,
    output logic interrupt_out_b_b,
    output logic irq
);

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [7:0] rdata;
        logic [7:0] port_b;
        logic [3:0] irq_stat;
        logic [3:0] irq_en;
        logic irq_a_b;
        logic irq_b_b;
        logic irq;
        logic a2_out;
        logic a2_oe;
        logic b2_out;
        logic b2_oe;
    } pcl_top_state_t;

    pcl_top_state_t q, d;
    logic [7:0] ctrl_a, ctrl_b;
    logic a2_out, a2_oe, b2_out, b2_oe;
    logic ev_a1, ev_a2, ev_b1, ev_b2;
    logic sel_ctrl_a_wr, sel_ctrl_b_wr, rd_a, rd_b, wr_b;

    function automatic logic side_irq(input logic [7:0] c);
        side_irq = (c[`PCL_BIT_FLAG1] && c[`PCL_BIT_EN1])
            || (c[`PCL_BIT_FLAG2] && c[`PCL_BIT_EN2] && !c[`PCL_BIT_OUT2]);
    endfunction

    function automatic logic hit(input logic [`PCL_ADDR_W-1:0] a,
                                 input logic [`PCL_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    assign sel_ctrl_a_wr = reg_wr && hit(reg_addr, `PCL_OFF_CTRL_A);
    assign sel_ctrl_b_wr = reg_wr && hit(reg_addr, `PCL_OFF_CTRL_B);
    assign rd_a = reg_rd && hit(reg_addr, `PCL_OFF_DATA_A);
    assign rd_b = reg_rd && hit(reg_addr, `PCL_OFF_DATA_B);
    assign wr_b = reg_wr && hit(reg_addr, `PCL_OFF_DATA_B);

    pcl_side #(
        .WRITE_SIDE(1'b0)
    ) u_side_a (
        .clk(clk),
        .rst_b(rst_b),
        .ctrl_wr(sel_ctrl_a_wr),
        .ctrl_wdata(reg_wdata[5:0]),
        .data_rd(rd_a),
        .data_wr(1'b0),
        .edge1_sync(q.s2[0]),
        .line2_sync(q.s2[1]),
        .ctrl(ctrl_a),
        .line2_out(a2_out),
        .line2_oe(a2_oe),
        .ev_flag1(ev_a1),
        .ev_flag2(ev_a2)
    );

    pcl_side #(
        .WRITE_SIDE(1'b1)
    ) u_side_b (
        .clk(clk),
        .rst_b(rst_b),
        .ctrl_wr(sel_ctrl_b_wr),
        .ctrl_wdata(reg_wdata[5:0]),
        .data_rd(rd_b),
        .data_wr(wr_b),
        .edge1_sync(q.s2[2]),
        .line2_sync(q.s2[3]),
        .ctrl(ctrl_b),
        .line2_out(b2_out),
        .line2_oe(b2_oe),
        .ev_flag1(ev_b1),
        .ev_flag2(ev_b2)
    );

    always_comb begin
        d = q;
        // Two-stage pin synchroniser; only stage two feeds logic
        d.s1 = {control_line_b2_in, edge_input_b, control_line_a2_in, edge_input_a};
        d.s2 = q.s1;
        d.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `PCL_OFF_CTRL_A: d.rdata = ctrl_a;
                `PCL_OFF_CTRL_B: d.rdata = ctrl_b;
                `PCL_OFF_DATA_A: d.rdata = port_a_in;
                `PCL_OFF_DATA_B: d.rdata = q.port_b;
                `PCL_OFF_IRQ_STAT: d.rdata = {4'h0, q.irq_stat};
                `PCL_OFF_IRQ_EN: d.rdata = {4'h0, q.irq_en};
                default: d.rdata = 8'h00;
            endcase
        end
        if (wr_b) begin
            d.port_b = reg_wdata;
        end
        if (reg_wr && hit(reg_addr, `PCL_OFF_IRQ_EN)) begin
            d.irq_en = reg_wdata[3:0];
        end
        // Clear first, so a same-cycle event still sets
        if (reg_wr && hit(reg_addr, `PCL_OFF_IRQ_CLR)) begin
            d.irq_stat = q.irq_stat & ~reg_wdata[3:0];
        end
        d.irq_stat = d.irq_stat | {ev_b2, ev_b1, ev_a2, ev_a1};
        d.irq = |(q.irq_stat & q.irq_en);
        d.irq_a_b = !side_irq(ctrl_a);
        d.irq_b_b = !side_irq(ctrl_b);
        d.a2_out = a2_out;
        d.a2_oe = a2_oe;
        d.b2_out = b2_out;
        d.b2_oe = b2_oe;
        if (!rst_b) begin
            d = '0;
            d.port_b = `PCL_DATA_RST;
            d.irq_stat = `PCL_IRQ_RST;
            d.irq_en = `PCL_IRQ_RST;
            d.irq_a_b = 1'b1;
            d.irq_b_b = 1'b1;
            d.a2_out = 1'b1;
            d.b2_out = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    assign reg_rdata = q.rdata;
    assign port_b_out = q.port_b;
    assign control_line_a2_out = q.a2_out;
    assign control_line_a2_oe = q.a2_oe;
    assign control_line_b2_out = q.b2_out;
    assign control_line_b2_oe = q.b2_oe;
    assign interrupt_out_a_b = q.irq_a_b;
    assign interrupt_out_b_b = q.irq_b_b;
    assign irq = q.irq;

endmodule

//--- rtl/pcl_params.svh
`ifndef PCL_PARAMS_SVH
`define PCL_PARAMS_SVH

// Register offsets (plain register port, 3-bit address)
`define PCL_ADDR_W 3
`define PCL_OFF_CTRL_A 3'h0
`define PCL_OFF_CTRL_B 3'h1
`define PCL_OFF_DATA_A 3'h2
`define PCL_OFF_DATA_B 3'h3
`define PCL_OFF_IRQ_STAT 3'h4
`define PCL_OFF_IRQ_EN 3'h5
`define PCL_OFF_IRQ_CLR 3'h6

// Side control register fields
`define PCL_BIT_EN1 0
`define PCL_BIT_POL1 1
`define PCL_BIT_EN2 3
`define PCL_BIT_POL2 4
`define PCL_BIT_OUT2 5
`define PCL_BIT_FLAG2 6
`define PCL_BIT_FLAG1 7

// Reset values
`define PCL_CTRL_RST 8'h00
`define PCL_DATA_RST 8'h00
`define PCL_IRQ_RST 4'h0

`endif

//--- rtl/pcl_pkg.sv
package pcl_pkg;

    typedef enum logic [3:0] {
        PCL_M_INPUT = 4'b0001,
        PCL_M_HSHAKE = 4'b0010,
        PCL_M_PULSE = 4'b0100,
        PCL_M_MANUAL = 4'b1000
    } pcl_mode_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic line2;
    } pcl_side_t;

endpackage

//--- rtl/pcl_side.sv
`timescale 1ns/1ps
`include "pcl_params.svh"

module pcl_side
    import pcl_pkg::*;
#(
    parameter bit WRITE_SIDE = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Software access
    input wire logic ctrl_wr,
    input wire logic [5:0] ctrl_wdata,
    input wire logic data_rd,
    input wire logic data_wr,
    // Synchronised pins
    input wire logic edge1_sync,
    input wire logic line2_sync,
    // State
    output logic [7:0] ctrl,
    output logic line2_out,
    output logic line2_oe,
    output logic ev_flag1,
    output logic ev_flag2
);

    typedef struct packed {
        pcl_side_t s;
        logic e1_prev;
        logic l2_prev;
    } pcl_side_state_t;

    pcl_side_state_t q, d;
    pcl_mode_t mode;
    logic act1, act2, access;

    function automatic logic active_edge(input logic prev, input logic now, input logic rise);
        active_edge = rise ? (!prev && now) : (prev && !now);
    endfunction

    always_comb begin
        if (!q.s.ctrl[`PCL_BIT_OUT2]) begin
            mode = PCL_M_INPUT;
        end else if (q.s.ctrl[`PCL_BIT_POL2]) begin
            mode = PCL_M_MANUAL;
        end else if (q.s.ctrl[`PCL_BIT_EN2]) begin
            mode = PCL_M_PULSE;
        end else begin
            mode = PCL_M_HSHAKE;
        end
    end

    assign act1 = active_edge(q.e1_prev, edge1_sync, q.s.ctrl[`PCL_BIT_POL1]);
    assign act2 = active_edge(q.l2_prev, line2_sync, q.s.ctrl[`PCL_BIT_POL2]);
    assign access = WRITE_SIDE ? data_wr : data_rd;

    always_comb begin
        d = q;
        d.e1_prev = edge1_sync;
        d.l2_prev = line2_sync;
        if (ctrl_wr) begin
            d.s.ctrl[5:0] = ctrl_wdata;
        end
        // Read of port data clears both flags; a same-cycle edge wins
        if (data_rd) begin
            d.s.ctrl[`PCL_BIT_FLAG1] = 1'b0;
            d.s.ctrl[`PCL_BIT_FLAG2] = 1'b0;
        end
        if (act1) begin
            d.s.ctrl[`PCL_BIT_FLAG1] = 1'b1;
        end
        if (act2 && mode == PCL_M_INPUT) begin
            d.s.ctrl[`PCL_BIT_FLAG2] = 1'b1;
        end
        case (mode)
            PCL_M_INPUT: begin
                d.s.line2 = 1'b1;
            end
            PCL_M_HSHAKE: begin
                if (access) begin
                    d.s.line2 = 1'b0;
                end else if (act1) begin
                    d.s.line2 = 1'b1;
                end
            end
            PCL_M_PULSE: begin
                d.s.line2 = !access;
            end
            PCL_M_MANUAL: begin
                d.s.line2 = q.s.ctrl[`PCL_BIT_EN2];
            end
            default: begin
                d.s.line2 = 1'b1;
            end
        endcase
        if (ctrl_wr && ctrl_wdata[`PCL_BIT_OUT2] && ctrl_wdata[`PCL_BIT_POL2]) begin
            d.s.line2 = ctrl_wdata[`PCL_BIT_EN2];
        end
        if (!rst_b) begin
            d = '0;
            d.s.ctrl = `PCL_CTRL_RST;
            d.s.line2 = 1'b1;
            d.e1_prev = 1'b0;
            d.l2_prev = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    assign ctrl = q.s.ctrl;
    assign line2_out = q.s.line2;
    assign line2_oe = (mode != PCL_M_INPUT);
    assign ev_flag1 = act1;
    assign ev_flag2 = act2 && mode == PCL_M_INPUT;

endmodule

//--- testbench/pcl_periph_model.sv
`timescale 1ns/1ps
module pcl_periph_model #(
    parameter logic [3:0] WAIT_N = 4'h8
) (
    // Clock and device line 2 levels
    input wire logic clk,
    input wire logic line_a2,
    input wire logic line_b2,
    // Bench requests
    input wire logic poke_a,
    input wire logic poke_b,
    // Device edge inputs
    output logic edge_a,
    output logic edge_b
);
    logic [3:0] cnt_a = 4'h0;
    logic [3:0] cnt_b = 4'h0;
    logic a2_q = 1'b1;
    logic b2_q = 1'b1;
    // New data after a read, acknowledge after a write
    always @(posedge clk) begin
        a2_q <= line_a2;
        b2_q <= line_b2;
        if (poke_a || (a2_q && !line_a2))
            cnt_a <= WAIT_N;
        else if (cnt_a != 4'h0)
            cnt_a <= cnt_a - 4'h1;
        if (poke_b || (b2_q && !line_b2))
            cnt_b <= WAIT_N;
        else if (cnt_b != 4'h0)
            cnt_b <= cnt_b - 4'h1;
    end
    assign edge_a = cnt_a inside {[4'h1:4'h4]};
    assign edge_b = cnt_b inside {[4'h1:4'h4]};
endmodule

//--- testbench/pcl_top_checker.sv
`timescale 1ns/1ps
module pcl_top_checker (
    // Clock, reset, register port
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    // Lines
    input wire logic edge_input_b,
    input wire logic control_line_a2_out,
    input wire logic control_line_a2_oe,
    input wire logic control_line_b2_out,
    input wire logic interrupt_out_a_b,
    input wire logic interrupt_out_b_b,
    input wire logic irq
);
    logic [5:0] ca_q;
    logic [5:0] cb_q;
    wire rda = reg_rd && reg_addr == 3'h2;
    wire wrb = reg_wr && reg_addr == 3'h3;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ca_q <= 6'h00;
            cb_q <= 6'h00;
        end else if (reg_wr && reg_addr == 3'h0)
            ca_q <= reg_wdata[5:0];
        else if (reg_wr && reg_addr == 3'h1)
            cb_q <= reg_wdata[5:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_pa; rda && ca_q[5:3] == 3'b101 |-> ##2 !control_line_a2_out ##1 control_line_a2_out;
    endproperty
    a_pa: assert property (p_pa) else $error("a2 pulse bad");
    property p_ha; rda && ca_q[5:3] == 3'b100 |-> ##2 !control_line_a2_out; endproperty
    a_ha: assert property (p_ha) else $error("a2 handshake bad");
    property p_pb; wrb && cb_q[5:3] == 3'b101 |-> ##2 !control_line_b2_out ##1 control_line_b2_out;
    endproperty
    a_pb: assert property (p_pb) else $error("b2 pulse bad");
    property p_hb; wrb && cb_q[5:3] == 3'b100 |-> ##2 !control_line_b2_out; endproperty
    a_hb: assert property (p_hb) else $error("b2 handshake bad");
    property p_ack; cb_q[5:3] == 3'b100 && cb_q[1] && $rose(edge_input_b)
        |-> ##[1:6] control_line_b2_out;
    endproperty
    a_ack: assert property (p_ack) else $error("b2 ack bad");
    property p_man; (ca_q[5:4] == 2'b11 && $stable(ca_q)) [*3] |-> control_line_a2_out == ca_q[3];
    endproperty
    a_man: assert property (p_man) else $error("a2 manual bad");
    property p_in; (!ca_q[5]) [*3] |-> !control_line_a2_oe; endproperty
    a_in: assert property (p_in) else $error("a2 driven in input mode");
    property p_ia; (!ca_q[0] && !ca_q[3]) [*3] |-> interrupt_out_a_b; endproperty
    a_ia: assert property (p_ia) else $error("irq a not gated");
    property p_ib; (!cb_q[0] && !cb_q[3]) [*3] |-> interrupt_out_b_b; endproperty
    a_ib: assert property (p_ib) else $error("irq b not gated");
    c_pa: cover property (rda ##2 !control_line_a2_out);
    c_hb: cover property (wrb ##2 !control_line_b2_out);
    c_irq: cover property ($rose(irq));
endmodule
bind pcl_top pcl_top_checker chk_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .edge_input_b(edge_input_b),
    .control_line_a2_out(control_line_a2_out), .control_line_a2_oe(control_line_a2_oe),
    .control_line_b2_out(control_line_b2_out), .interrupt_out_a_b(interrupt_out_a_b),
    .interrupt_out_b_b(interrupt_out_b_b), .irq(irq));

//--- testbench/pcl_top_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module pcl_top_tb;
    typedef struct {logic s; logic [7:0] c; logic k; logic [1:0] lv;
        logic [1:0] f; logic ib;} pcl_row_t;
    pcl_row_t rows [6] = '{'{0, 8'h00, 0, 2'b10, 2'b01, 1}, '{0, 8'h08, 0, 2'b10, 2'b01, 0},
        '{1, 8'h10, 0, 2'b10, 2'b00, 1}, '{1, 8'h18, 0, 2'b01, 2'b01, 0},
        '{0, 8'h01, 1, 2'b11, 2'b10, 0}, '{1, 8'h02, 1, 2'b11, 2'b10, 1}};
    logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, poke_a = 0, poke_b = 0;
    logic [2:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, rdata, port_b, port_a_in = 8'h3c;
    logic [1:0] l2 = 2'b11;
    logic ea, eb, a2, a2_oe, b2, b2_oe, ia_b, ib_b, irq;
    int bad_count = 0, n_compared = 0, cyc = 0;
    wire w_a2 = a2_oe ? a2 : l2[0];
    wire w_b2 = b2_oe ? b2 : l2[1];
    always #5 clk = ~clk;
    pcl_top dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .port_a_in(port_a_in),
        .port_b_out(port_b), .edge_input_a(ea), .control_line_a2_in(w_a2),
        .control_line_a2_out(a2), .control_line_a2_oe(a2_oe), .edge_input_b(eb),
        .control_line_b2_in(w_b2), .control_line_b2_out(b2), .control_line_b2_oe(b2_oe),
        .interrupt_out_a_b(ia_b), .interrupt_out_b_b(ib_b), .irq(irq));
    pcl_periph_model per_u (.clk(clk), .line_a2(a2), .line_b2(b2), .poke_a(poke_a),
        .poke_b(poke_b), .edge_a(ea), .edge_b(eb));
    task automatic summarize;
        $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 `CHK(rdata, e)
    endtask
    task automatic poke(input logic s);
        @(posedge clk);
        poke_a <= !s;
        poke_b <= s;
        @(posedge clk);
        poke_a <= 1'b0;
        poke_b <= 1'b0;
        repeat (16) @(posedge clk);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            bad_count++;
            summarize;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            wr({2'b00, rows[i].s}, rows[i].c);
            l2[rows[i].s] <= rows[i].lv[1];
            repeat (6) @(posedge clk);
            if (rows[i].k)
                poke(rows[i].s);
            else
                l2[rows[i].s] <= rows[i].lv[0];
            tick(8);
            rd({2'b00, rows[i].s}, {rows[i].f, rows[i].c[5:0]});
            `CHK(rows[i].s ? ib_b : ia_b, rows[i].ib)
            rd({2'b01, rows[i].s}, rows[i].s ? 8'h00 : 8'h3c);
            rd({2'b00, rows[i].s}, {2'b00, rows[i].c[5:0]});
        end
        wr(3'h0, 8'h28);
        rd(3'h2, 8'h3c);
        tick(1); `CHK(a2, 1'b0)
        tick(1); `CHK(a2, 1'b1)
        wr(3'h0, 8'h22);
        rd(3'h2, 8'h3c);
        tick(1); `CHK(a2, 1'b0)
        tick(14); `CHK(a2, 1'b1)
        wr(3'h1, 8'h22);
        wr(3'h3, 8'h5a);
        tick(1); `CHK({port_b, b2}, 9'h0b4)
        tick(14); `CHK(b2, 1'b1)
        wr(3'h1, 8'h28);
        wr(3'h3, 8'ha5);
        tick(1); `CHK(b2, 1'b0)
        tick(1); `CHK(b2, 1'b1)
        wr(3'h0, 8'h38);
        wr(3'h1, 8'h30);
        tick(3); `CHK({a2, a2_oe, b2, b2_oe}, 4'b1101)
        wr(3'h0, 8'h30);
        wr(3'h1, 8'h38);
        tick(3); `CHK({a2, a2_oe, b2, b2_oe}, 4'b0111)
        // Let peripheral replies to the manual edges die out before clearing
        tick(16);
        wr(3'h6, 8'h0f);
        wr(3'h5, 8'h01);
        wr(3'h0, 8'h03);
        poke(1'b0);
        rd(3'h4, 8'h01);
        `CHK({ia_b, irq}, 2'b01)
        wr(3'h5, 8'h00);
        tick(2); `CHK(irq, 1'b0)
        wr(3'h5, 8'h01);
        wr(3'h6, 8'h01);
        tick(2); `CHK(irq, 1'b0)
        rd(3'h5, 8'h01);
        rd(3'h7, 8'h00);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        #1 `CHK({a2, a2_oe, b2, b2_oe, ia_b, ib_b, irq, port_b}, 15'h5600)
        rd(3'h0, 8'h00);
        summarize;
    end
endmodule
